// ### ddr2_ctl_inputs.sv
/*
  DDR2 device-side control inputs: command sampling and decode, bank and
  mode-register tracking, CKE power states, input buffer gating, on-die
  termination enables, write data masking and read drive timing.
  Assumes clk_i is the sampled CK/CK# crossing and all pins are synchronous.
*/
`timescale 1ns/100ps

// What this block does
// R1: Bank address picks one of eight banks for ACTIVE, READ, WRITE, PRECHARGE.
// R2: Bank address picks MR, EMR, EMR2 or EMR3 during LOAD MODE.
// R3: All address and control pins are sampled on the rising clock crossing.
// R4: Driven data and strobe are timed from the clock crossings.
// R5: CKE registered high runs internal clocking; registered low stops it.
// R6: CKE low enters precharge power-down or self refresh when idle, else active power-down; code enters self refresh on REFRESH even with banks open.
// R7: CKE synchronous for power-down and self refresh entry; self refresh exit asynchronous.
// R8: In power-down only clock, CKE and ODT input buffers stay on.
// R9: In self refresh only the CKE input buffer stays on.
// R10: Commands decode only with chip select low; chip select high masks all.
// R11: Command is chip select plus row, column strobes and write enable, same cycle.
// R12: Data mask sampled on both strobe edges; masked byte lanes of a write beat are not enabled.
// R13: On sixteen-bit parts lower mask covers low byte, upper covers high byte.
// R14: ODT registered high enables termination on data, strobe and mask balls only.
// R15: ODT is ignored when termination is disabled by LOAD MODE.
// R16: Data bus width is four, eight or sixteen bits by configuration.
// R17: PRECHARGE with A10 low closes the addressed bank, high closes all.
// R18: Command encoding follows the standard DDR2 truth table.
module ddr2_ctl_inputs
    import ddr2_ctl_pkg::*;
#(
    parameter int DQ_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire cmd_pins_t cmd_i,
    input wire logic cke_i,
    input wire logic odt_i,
    input wire logic [DQ_MAX-1:0] dq_i,
    output logic [DQ_MAX-1:0] dq_o,
    output logic dq_oe_n_o,
    input wire logic [LANES_MAX-1:0] dm_i,
    input wire logic dqs_i,
    output logic dqs_o,
    output logic dqs_oe_n_o,
    input wire logic rd_valid_i,
    input wire logic [DQ_MAX-1:0] rd_data_i,
    output cmd_t cmd_o,
    output logic [BA_W-1:0] cmd_bank_o,
    output logic [ADDR_W-1:0] cmd_addr_o,
    output logic [NUM_BANKS-1:0] bank_open_o,
    output logic [ADDR_W-1:0] ext_mode_o,
    output pwr_state_t pwr_state_o,
    output logic clk_run_o,
    output logic cmd_ibuf_en_o,
    output logic odt_ibuf_en_o,
    output term_map_t term_o,
    output logic wr_valid_o,
    output logic [DQ_MAX-1:0] wr_data_o,
    output logic [LANES_MAX-1:0] wr_be_o
);

    localparam int LANES = (DQ_W == DQ_MAX) ? LANES_MAX : 1;
    localparam logic [DQ_MAX-1:0] DQ_MASK = DQ_MAX'((32'h1 << DQ_W) - 32'h1);
    localparam logic [LANES_MAX-1:0] LANE_MASK = LANES_MAX'((32'h1 << LANES) - 32'h1);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    pwr_state_t state_q, state_d;
    cmd_t cmd_q;
    logic [BA_W-1:0] ba_q;
    logic [ADDR_W-1:0] addr_q;
    logic [NUM_BANKS-1:0] bank_open_q;
    logic [ADDR_W-1:0] mr_q [MR_NUM];
    logic cke_q;
    logic odt_q;
    logic wr_win_q;
    logic dqs_prev_q;
    logic [DQ_MAX-1:0] dq_out_q;
    logic drive_q;
    logic dqs_out_q;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    wire in_active = (state_q == PS_ACTIVE);
    wire in_sref = (state_q == PS_SREF);
    wire in_pd = (state_q == PS_PD_PRE) || (state_q == PS_PD_ACT);
    wire [3:0] pin_code = {1'b0, cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};
    wire cmd_sel = in_active && !cmd_i.cs_n; // R8 R9 R10
    wire cmd_t cmd_d = cmd_sel ? cmd_t'(pin_code) : CMD_DESEL; // R11 R18
    wire pin_ref = !cmd_i.cs_n && (cmd_t'(pin_code) == CMD_REF);
    wire a10_q = addr_q[A10_POS];
    wire lmr_ok = (cmd_q == CMD_LMR) && !ba_q[BA_HI_POS];
    wire [MR_SEL_W-1:0] mr_sel = ba_q[MR_SEL_W-1:0];
    wire rtt_on = mr_q[EMR_SEL][RTT_LO_POS] | mr_q[EMR_SEL][RTT_HI_POS];
    wire any_open = |bank_open_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_q <= CMD_DESEL;
            ba_q <= '0;
            addr_q <= '0;
        end else begin
            cmd_q <= cmd_d; // R3
            ba_q <= cmd_i.ba;
            addr_q <= cmd_i.addr;
        end
    end

    // ----------------------------------------------------------------
    // Bank open tracking, one flag per bank
    // ----------------------------------------------------------------
    generate
        for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
            wire hit = (ba_q == BA_W'(b));
            wire open_set = (cmd_q == CMD_ACT) && hit; // R1
            wire pre_clr = (cmd_q == CMD_PRE) && (a10_q || hit); // R17
            wire ap_clr = ((cmd_q == CMD_RD) || (cmd_q == CMD_WR)) && hit && a10_q;
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    bank_open_q[b] <= 1'b0;
                end else if (open_set) begin
                    bank_open_q[b] <= 1'b1;
                end else if (pre_clr || ap_clr) begin
                    bank_open_q[b] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Mode registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < MR_NUM; i++) begin
                mr_q[i] <= MR_RST;
            end
        end else if (lmr_ok) begin
            mr_q[mr_sel] <= addr_q; // R2
        end
    end

    // ----------------------------------------------------------------
    // Power state machine
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            PS_ACTIVE: begin
                if (!cke_i) begin
                    if (pin_ref) begin
                        state_d = PS_SREF; // R6 R7
                    end else if (any_open) begin
                        state_d = PS_PD_ACT; // R6
                    end else begin
                        state_d = PS_PD_PRE; // R6
                    end
                end
            end
            PS_PD_PRE, PS_PD_ACT: begin
                if (cke_i) begin
                    state_d = PS_ACTIVE; // R7
                end
            end
            PS_SREF: begin
                if (cke_i) begin
                    state_d = PS_ACTIVE;
                end
            end
            default: begin
                state_d = PS_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= PS_ACTIVE;
            cke_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cke_q <= cke_i;
        end
    end

    // Self refresh wakes on CKE without waiting for an edge
    assign clk_run_o = (cke_q && !in_sref) || (in_sref && cke_i); // R5 R7
    assign cmd_ibuf_en_o = in_active; // R8 R9
    assign odt_ibuf_en_o = !in_sref; // R8 R9

    // ----------------------------------------------------------------
    // On-die termination
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            odt_q <= 1'b0;
        end else begin
            odt_q <= odt_ibuf_en_o && odt_i; // R9
        end
    end

    wire term_en = odt_q && rtt_on; // R14 R15
    assign term_o.dq = term_en ? DQ_MASK : '0; // R14 R16
    assign term_o.dm = term_en ? LANE_MASK : '0;
    assign term_o.dqs = term_en ? LANE_MASK : '0;

    // ----------------------------------------------------------------
    // Write data: one beat per strobe edge inside a write window
    // ----------------------------------------------------------------
    wire dqs_edge = (dqs_i != dqs_prev_q);
    wire beat_valid = wr_win_q && dqs_edge && !in_sref; // R12
    wire wr_beat_t beat = '{dq: dq_i, dm: dm_i};
    wire win_end = (cmd_q != CMD_NOP) && (cmd_q != CMD_DESEL) && (cmd_q != CMD_WR);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_win_q <= 1'b0;
            dqs_prev_q <= 1'b0;
        end else begin
            dqs_prev_q <= dqs_i;
            if (cmd_q == CMD_WR) begin
                wr_win_q <= 1'b1;
            end else if (win_end || !in_active) begin
                wr_win_q <= 1'b0;
            end
        end
    end

    beat_mask #(
        .DQ_W(DQ_W)
    ) u_beat_mask (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .valid_i(beat_valid),
        .beat_i(beat),
        .valid_o(wr_valid_o),
        .data_o(wr_data_o),
        .be_o(wr_be_o)
    );

    // ----------------------------------------------------------------
    // Read drive: data and strobe launched on the clock edge
    // ----------------------------------------------------------------
    wire drive_d = rd_valid_i && cke_i && in_active; // R7
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dq_out_q <= '0;
            drive_q <= 1'b0;
            dqs_out_q <= 1'b0;
        end else begin
            dq_out_q <= rd_data_i & DQ_MASK; // R4 R16
            drive_q <= drive_d;
            dqs_out_q <= drive_d ? !dqs_out_q : 1'b0; // R4
        end
    end

    assign dq_o = dq_out_q;
    assign dq_oe_n_o = !drive_q;
    assign dqs_o = dqs_out_q;
    assign dqs_oe_n_o = !drive_q;

    assign cmd_o = cmd_q;
    assign cmd_bank_o = ba_q;
    assign cmd_addr_o = addr_q;
    assign bank_open_o = bank_open_q;
    assign ext_mode_o = mr_q[EMR_SEL];
    assign pwr_state_o = state_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_cs_mask;
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_active && cmd_i.cs_n) |=> (cmd_o == CMD_DESEL);
    endproperty
    a_cs_mask: assert property (p_cs_mask) else $error("command not masked by chip select"); // R10

    property p_cmd_form;
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_active && !cmd_i.cs_n) |=> (cmd_o[2:0] == {$past(cmd_i.ras_n), $past(cmd_i.cas_n), $past(cmd_i.we_n)})
            && !cmd_o[3];
    endproperty
    a_cmd_form: assert property (p_cmd_form) else $error("command code differs from pins"); // R11

    property p_bank_act;
        @(posedge clk_i) disable iff (!rst_n_i)
        (cmd_o == CMD_ACT) |=> bank_open_o[$past(cmd_bank_o)];
    endproperty
    a_bank_act: assert property (p_bank_act) else $error("activated bank not open"); // R1

    property p_pre_all;
        @(posedge clk_i) disable iff (!rst_n_i)
        (cmd_o == CMD_PRE && cmd_addr_o[A10_POS]) |=> (bank_open_o == '0);
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open"); // R17

    property p_lmr;
        @(posedge clk_i) disable iff (!rst_n_i)
        (cmd_o == CMD_LMR && cmd_bank_o == BA_W'(EMR_SEL)) |=> (ext_mode_o == $past(cmd_addr_o));
    endproperty
    a_lmr: assert property (p_lmr) else $error("extended mode register not loaded"); // R2

    property p_pd_entry;
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_active && !cke_i && !pin_ref && any_open) |=> (pwr_state_o == PS_PD_ACT) && !cmd_ibuf_en_o;
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("active power-down not entered"); // R6 R8

    property p_sref_bufs;
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_active && !cke_i && pin_ref) |=> (!odt_ibuf_en_o && !cmd_ibuf_en_o) ##1 (term_o.dq == '0);
    endproperty
    a_sref_bufs: assert property (p_sref_bufs) else $error("buffers live in self refresh"); // R9

    property p_sref_wake;
        @(posedge clk_i) disable iff (!rst_n_i)
        (in_sref && cke_i) |-> clk_run_o ##1 (pwr_state_o == PS_ACTIVE);
    endproperty
    a_sref_wake: assert property (p_sref_wake) else $error("self refresh exit missed"); // R7

    property p_odt_ignored;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!rtt_on) |-> (term_o.dq == '0) && (term_o.dm == '0);
    endproperty
    a_odt_ignored: assert property (p_odt_ignored) else $error("termination on while disabled"); // R15

    property p_mask;
        @(posedge clk_i) disable iff (!rst_n_i)
        (beat_valid && dm_i[0]) |=> wr_valid_o && !wr_be_o[0];
    endproperty
    a_mask: assert property (p_mask) else $error("masked beat written"); // R12 R13

endmodule : ddr2_ctl_inputs

// ### ddr2_ctl_pkg.sv
/*
  Shared constants and types for the DDR2 control-input block: pin groups,
  command codes, power states and mode-register field positions.
  Assumes one clock domain; every pin group is synchronous to clk_i.
*/
package ddr2_ctl_pkg;

    // ----------------------------------------------------------------
    // Widths and field positions
    // ----------------------------------------------------------------
    localparam int BA_W = 3;
    localparam int ADDR_W = 14;
    localparam int NUM_BANKS = 8;
    localparam int DQ_MAX = 16;
    localparam int LANES_MAX = 2;
    localparam int LANE_W = 8;
    localparam int MR_NUM = 4;
    localparam int MR_SEL_W = 2;
    localparam int A10_POS = 10;
    localparam int BA_HI_POS = 2;
    localparam int RTT_LO_POS = 2;
    localparam int RTT_HI_POS = 6;
    localparam logic [MR_SEL_W-1:0] EMR_SEL = 2'h1;
    localparam logic [ADDR_W-1:0] MR_RST = 14'h0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    // Code is {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        CMD_LMR = 4'h0,
        CMD_REF = 4'h1,
        CMD_PRE = 4'h2,
        CMD_ACT = 4'h3,
        CMD_WR = 4'h4,
        CMD_RD = 4'h5,
        CMD_BST = 4'h6,
        CMD_NOP = 4'h7,
        CMD_DESEL = 4'hf
    } cmd_t;

    typedef enum logic [3:0] {
        PS_ACTIVE = 4'h1,
        PS_PD_PRE = 4'h2,
        PS_PD_ACT = 4'h4,
        PS_SREF = 4'h8
    } pwr_state_t;

    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
    } cmd_pins_t;

    typedef struct packed {
        logic [DQ_MAX-1:0] dq;
        logic [LANES_MAX-1:0] dm;
    } wr_beat_t;

    typedef struct packed {
        logic [DQ_MAX-1:0] dq;
        logic [LANES_MAX-1:0] dm;
        logic [LANES_MAX-1:0] dqs;
    } term_map_t;

endpackage : ddr2_ctl_pkg

// ### beat_mask.sv
/*
  Write beat masking: registers one write data beat and turns the data
  mask into per-byte-lane write enables.
  Assumes the caller presents one beat per strobe edge, synchronous to clk_i.
*/
`timescale 1ns/100ps
module beat_mask
    import ddr2_ctl_pkg::*;
#(
    parameter int DQ_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic valid_i,
    input wire wr_beat_t beat_i,
    output logic valid_o,
    output logic [DQ_MAX-1:0] data_o,
    output logic [LANES_MAX-1:0] be_o
);

    localparam int LANES = (DQ_W == DQ_MAX) ? LANES_MAX : 1;
    localparam logic [DQ_MAX-1:0] DQ_MASK = DQ_MAX'((32'h1 << DQ_W) - 32'h1);

    logic [LANES_MAX-1:0] keep;

    // ----------------------------------------------------------------
    // Lane enables: a lane is written only when its mask is low
    // ----------------------------------------------------------------
    generate
        for (genvar j = 0; j < LANES_MAX; j++) begin : g_lane
            if (j < LANES) begin : g_used
                assign keep[j] = valid_i & ~beat_i.dm[j]; // R12 R13
            end else begin : g_unused
                assign keep[j] = 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_o <= 1'b0;
            data_o <= '0;
            be_o <= '0;
        end else begin
            valid_o <= valid_i;
            data_o <= beat_i.dq & DQ_MASK; // R16
            be_o <= keep;
        end
    end

endmodule : beat_mask

// ### ddr2_host_model.sv
/*
  Memory controller model: drives command, CKE, ODT, write beats and read beats.
  Assumes the bench calls its tasks and that clk_i is the bench clock.
*/
`timescale 1ns/100ps
module ddr2_host_model
    import ddr2_ctl_pkg::*;
(
    input wire logic clk_i,
    output cmd_pins_t cmd_o,
    output logic cke_o,
    output logic odt_o,
    output logic [DQ_MAX-1:0] dq_o,
    output logic [LANES_MAX-1:0] dm_o,
    output logic dqs_o,
    output logic rd_valid_o,
    output logic [DQ_MAX-1:0] rd_data_o
);
    initial begin
        cmd_o = {4'hf, 3'h0, 14'h0000};
        cke_o = 1'b1;
        odt_o = 1'b0;
        dq_o = 16'h5a5a;
        dm_o = 2'h0;
        dqs_o = 1'b0;
        rd_valid_o = 1'b0;
        rd_data_o = 16'h0000;
    end

    // Code is {cs_n, ras_n, cas_n, we_n}, sent with bank and address
    task automatic send(input logic [3:0] code, input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] addr);
        @(posedge clk_i);
        cmd_o <= {code, ba, addr};
        dq_o <= ~dq_o;
    endtask : send

    // One write beat per strobe change
    task automatic beat(input logic [DQ_MAX-1:0] data, input logic [LANES_MAX-1:0] dm);
        @(posedge clk_i);
        cmd_o <= {CMD_NOP, 3'h0, 14'h0000};
        dq_o <= data;
        dm_o <= dm;
        dqs_o <= ~dqs_o;
    endtask : beat

    task automatic power(input logic cke, input logic [3:0] code);
        @(posedge clk_i);
        cke_o <= cke;
        cmd_o <= {code, 3'h0, 14'h0000};
    endtask : power

    task automatic term(input logic v);
        @(posedge clk_i);
        odt_o <= v;
    endtask : term

    task automatic read(input logic [DQ_MAX-1:0] data);
        @(posedge clk_i);
        rd_valid_o <= 1'b1;
        rd_data_o <= data;
        @(posedge clk_i);
        rd_valid_o <= 1'b0;
        rd_data_o <= ~data;
    endtask : read
endmodule : ddr2_host_model

// ### testbench.sv
/*
  Self-checking bench for the DDR2 control-input block with a controller model.
  Assumes the x16 configuration and a 25 MHz clock.
*/
`timescale 1ns/100ps
`define CHK(name, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            $display("mismatch %s expected %h seen %h", name, exp, got); \
            fail_count++; \
        end \
    end
module testbench
    import ddr2_ctl_pkg::*;
;
    typedef struct {time t; cmd_t cmd; logic [BA_W-1:0] ba; logic [ADDR_W-1:0] addr;} cmd_note_t;
    typedef struct {logic [DQ_MAX-1:0] data; logic [LANES_MAX-1:0] be;} wr_note_t;
    logic clk_i, rst_n_i, cke_i, odt_i, dqs_i, rd_valid_i, dq_oe_n_o, dqs_o, dqs_oe_n_o;
    logic clk_run_o, cmd_ibuf_en_o, odt_ibuf_en_o, wr_valid_o;
    cmd_pins_t cmd_i;
    logic [DQ_MAX-1:0] dq_i, rd_data_i, dq_o, wr_data_o;
    logic [LANES_MAX-1:0] dm_i, wr_be_o;
    cmd_t cmd_o;
    logic [BA_W-1:0] cmd_bank_o;
    logic [ADDR_W-1:0] cmd_addr_o, ext_mode_o;
    logic [NUM_BANKS-1:0] bank_open_o;
    pwr_state_t pwr_state_o;
    term_map_t term_o;
    cmd_note_t cq[$];
    wr_note_t wq[$];
    int fail_count = 0;
    int compares = 0;
    logic [31:0] seed = 32'h3752fdf4;
    cmd_t codes[8] = '{CMD_LMR, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD, CMD_BST, CMD_NOP};

    ddr2_ctl_inputs #(.DQ_W(16)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .cke_i(cke_i),
        .odt_i(odt_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .dm_i(dm_i), .dqs_i(dqs_i),
        .dqs_o(dqs_o), .dqs_oe_n_o(dqs_oe_n_o), .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i),
        .cmd_o(cmd_o), .cmd_bank_o(cmd_bank_o), .cmd_addr_o(cmd_addr_o), .bank_open_o(bank_open_o),
        .ext_mode_o(ext_mode_o), .pwr_state_o(pwr_state_o), .clk_run_o(clk_run_o),
        .cmd_ibuf_en_o(cmd_ibuf_en_o), .odt_ibuf_en_o(odt_ibuf_en_o), .term_o(term_o),
        .wr_valid_o(wr_valid_o), .wr_data_o(wr_data_o), .wr_be_o(wr_be_o));

    ddr2_host_model u_host (.clk_i(clk_i), .cmd_o(cmd_i), .cke_o(cke_i), .odt_o(odt_i), .dq_o(dq_i),
        .dm_o(dm_i), .dqs_o(dqs_i), .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic cmd(input logic [3:0] code, input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] addr,
                       input cmd_t exp);
        cmd_note_t n;
        u_host.send(code, ba, addr);
        n.t = $time;
        n.cmd = exp;
        n.ba = ba;
        n.addr = addr;
        cq.push_back(n);
    endtask : cmd

    task automatic nop(input int n);
        repeat (n) u_host.send(CMD_NOP, 3'h0, 14'h0000);
        #1;
    endtask : nop

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        repeat (3000) @(posedge clk_i);
        fail_count++;
        complete_run();
    end

    // ----------------------------------------------------------------
    // Output monitor
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin : mon
        logic [DQ_MAX-1:0] m;
        #1;
        if (cq.size() > 0 && cq[0].t + 40 < $time) begin
            `CHK("cmd_o", cq[0].cmd, cmd_o)
            if (cq[0].cmd != CMD_DESEL) `CHK("cmd_bank_o", cq[0].ba, cmd_bank_o)
            `CHK("cmd_addr_o", cq[0].addr, cmd_addr_o)
            void'(cq.pop_front());
        end
        if (wr_valid_o === 1'b1) begin
            if (wq.size() == 0) begin
                `CHK("wr_valid_o", 1'b0, wr_valid_o)
            end else begin
                m = {{8{wq[0].be[1]}}, {8{wq[0].be[0]}}};
                `CHK("wr_be_o", wq[0].be, wr_be_o)
                `CHK("wr_data_o", wq[0].data & m, wr_data_o & m)
                void'(wq.pop_front());
            end
        end
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        wr_note_t w;
        rst_n_i = 1'b0;
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        `CHK("pwr_state_o", PS_ACTIVE, pwr_state_o)
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            cmd(codes[i], r[2:0], 14'h0000, codes[i]);
        end
        cmd(CMD_PRE, 3'h0, 14'h0400, CMD_PRE);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            cmd({1'b1, r[2:0]}, r[5:3], r[19:6], CMD_DESEL);
        end
        r = rnd();
        cmd(CMD_ACT, 3'h3, r[13:0], CMD_ACT);
        cmd(CMD_ACT, 3'h5, r[27:14], CMD_ACT);
        nop(2);
        `CHK("bank_open_o", 8'h28, bank_open_o)
        cmd(CMD_PRE, 3'h3, 14'h0000, CMD_PRE);
        nop(2);
        `CHK("bank_open_o", 8'h20, bank_open_o)
        cmd(CMD_PRE, 3'h0, 14'h0400, CMD_PRE);
        nop(2);
        `CHK("bank_open_o", 8'h00, bank_open_o)
        cmd(CMD_LMR, 3'h1, 14'h0004, CMD_LMR);
        nop(2);
        `CHK("ext_mode_o", 14'h0004, ext_mode_o)
        cmd(CMD_LMR, 3'h2, 14'h0044, CMD_LMR);
        nop(2);
        `CHK("ext_mode_o", 14'h0004, ext_mode_o)
        u_host.term(1'b1);
        nop(2);
        `CHK("term_o", {16'hffff, 2'h3, 2'h3}, term_o)
        u_host.term(1'b0);
        cmd(CMD_LMR, 3'h1, 14'h0000, CMD_LMR);
        nop(2);
        u_host.term(1'b1);
        nop(2);
        `CHK("term_o", 20'h00000, term_o)
        u_host.term(1'b0);
        r = rnd();
        cmd(CMD_WR, r[2:0], 14'h0000, CMD_WR);
        nop(1);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            w.data = r[15:0];
            w.be = ~r[17:16];
            wq.push_back(w);
            u_host.beat(r[15:0], r[17:16]);
        end
        cmd(CMD_PRE, 3'h0, 14'h0400, CMD_PRE);
        nop(1);
        u_host.beat(16'hffff, 2'h0);
        nop(3);
        `CHK("wr_beats_left", 0, wq.size())
        r = rnd();
        u_host.read(r[15:0]);
        #1;
        `CHK("dq_oe_n_o", 1'b0, dq_oe_n_o)
        `CHK("dq_o", r[15:0], dq_o)
        `CHK("dqs_o", 1'b1, dqs_o)
        `CHK("dqs_oe_n_o", 1'b0, dqs_oe_n_o)
        nop(1);
        `CHK("dq_oe_n_o", 1'b1, dq_oe_n_o)
        `CHK("dqs_oe_n_o", 1'b1, dqs_oe_n_o)
        cmd(CMD_ACT, 3'h6, 14'h0000, CMD_ACT);
        nop(1);
        u_host.power(1'b0, CMD_NOP);
        nop(1);
        `CHK("pwr_state_o", PS_PD_ACT, pwr_state_o)
        `CHK("cmd_ibuf_en_o", 1'b0, cmd_ibuf_en_o)
        `CHK("odt_ibuf_en_o", 1'b1, odt_ibuf_en_o)
        `CHK("clk_run_o", 1'b0, clk_run_o)
        cmd(CMD_RD, 3'h6, 14'h0000, CMD_DESEL);
        u_host.power(1'b1, CMD_NOP);
        nop(1);
        `CHK("pwr_state_o", PS_ACTIVE, pwr_state_o)
        `CHK("clk_run_o", 1'b1, clk_run_o)
        cmd(CMD_PRE, 3'h0, 14'h0400, CMD_PRE);
        nop(2);
        u_host.power(1'b0, CMD_NOP);
        nop(1);
        `CHK("pwr_state_o", PS_PD_PRE, pwr_state_o)
        u_host.power(1'b1, CMD_NOP);
        nop(1);
        u_host.power(1'b0, CMD_REF);
        nop(1);
        `CHK("pwr_state_o", PS_SREF, pwr_state_o)
        `CHK("odt_ibuf_en_o", 1'b0, odt_ibuf_en_o)
        u_host.power(1'b1, CMD_NOP);
        #1;
        `CHK("clk_run_o", 1'b1, clk_run_o)
        `CHK("pwr_state_o", PS_SREF, pwr_state_o)
        nop(1);
        `CHK("pwr_state_o", PS_ACTIVE, pwr_state_o)
        nop(2);
        complete_run();
    end
endmodule : testbench
